// ### verilog/interrupt_flag_status_bank.sv
// top: interrupt flag status bank behind an axi4-lite slave
`timescale 1ns/1ps
//
// Overview of operation
// - a flag reads one once its source requested, zero otherwise
// - group1 bit 15 serial2 transmit, bit 14 serial2 receive
// - pin2 at group1 bit 13, pin1 group1 bit 4, pin0 group0 bit 0
// - timer5 group1 bit 12, timer4 group1 bit 11, timer6 group2 bit 15
// - compare ch1 g0 bit 2; ch4,ch3 g1 bits 10,9; ch8..5 g2 bits 12..9
// - capture ch1 g0 bit 1; ch8,ch7 g1 bits 7,6; ch6..3 g2 bits 8..5
// - dma done: ch2 g1 bit 8, ch4 g2 bit 14, ch3 g2 bit 4
// - second converter done sets group1 bit 5
// - input change notification sets group1 bit 3
// - group1 bit 1 i2c1 master events, bit 0 i2c1 slave events
// - can1 event request sets group2 bit 3
// - can1 receive data ready sets group2 bit 2
// - group2 bit 1 spi2 events, bit 0 spi2 errors
// - group0 bit 15, group1 bit 2 and group2 bit 13 ignore writes, read zero
// - implemented flags are read/write and reset to zero
module interrupt_flag_status_bank (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // axi4-lite write address
  input wire logic [irq_flags_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [irq_flags_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // external interrupt pins, asynchronous
  input wire logic EXT_PIN0,
  input wire logic EXT_PIN1,
  input wire logic EXT_PIN2,
  // group 0 peripheral requests
  input wire logic CAPTURE_CH1_REQ,
  input wire logic COMPARE_CH1_REQ,
  input wire logic [11:0] GROUP0_AUX_REQ,
  // group 1 peripheral requests
  input wire logic SERIAL2_TX_REQ,
  input wire logic SERIAL2_RX_REQ,
  input wire logic TIMER_FIVE_REQ,
  input wire logic TIMER_FOUR_REQ,
  input wire logic COMPARE_CH4_REQ,
  input wire logic COMPARE_CH3_REQ,
  input wire logic DMA_CH2_DONE_REQ,
  input wire logic CAPTURE_CH8_REQ,
  input wire logic CAPTURE_CH7_REQ,
  input wire logic CONVERTER2_DONE_REQ,
  input wire logic PIN_CHANGE_REQ,
  input wire logic I2C1_MASTER_REQ,
  input wire logic I2C1_SLAVE_REQ,
  // group 2 peripheral requests
  input wire logic TIMER_SIX_REQ,
  input wire logic DMA_CH4_DONE_REQ,
  input wire logic [3:0] COMPARE_CH8_5_REQ,
  input wire logic [3:0] CAPTURE_CH6_3_REQ,
  input wire logic DMA_CH3_DONE_REQ,
  input wire logic CAN1_EVENT_REQ,
  input wire logic CAN1_RX_READY_REQ,
  input wire logic SPI2_EVENT_REQ,
  input wire logic SPI2_ERROR_REQ,
  // flag views for the core
  output logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP0,
  output logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP1,
  output logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP2,
  // combined interrupt, level
  output logic IRQ
);
  import irq_flags_pkg::*;

  // geometry that the port map and the decode rely on
  if (FLAG_W != 16) begin : g_bad_flag_width
    $error("flag registers must be 16 bits wide");
  end
  if (GROUPS != 3) begin : g_bad_groups
    $error("exactly three flag groups are wired to ports");
  end
  if (PIN_COUNT != 3) begin : g_bad_pins
    $error("exactly three external pins are wired to ports");
  end
  if (GROUP0_AUX_MSB - GROUP0_AUX_LSB != 11) begin : g_bad_aux
    $error("group0 auxiliary field must match its 12-bit port");
  end
  if (ADDR_W != 8) begin : g_bad_addr
    $error("address must be 8 bits to match the offset constants");
  end
  if (COMPARE_CH8_BIT - COMPARE_CH5_BIT != 3) begin : g_bad_compare
    $error("compare field must match its 4-bit port");
  end
  if (CAPTURE_CH6_BIT - CAPTURE_CH3_BIT != 3) begin : g_bad_capture
    $error("capture field must match its 4-bit port");
  end

  // write channel state
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [FLAG_W-1:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic write_now;
  // read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // flag, mask and pin state
  logic [GROUPS-1:0][FLAG_W-1:0] set_vec;
  logic [GROUPS-1:0][FLAG_W-1:0] flags;
  logic [GROUPS-1:0][FLAG_W-1:0] mask_reg;
  logic [GROUPS-1:0] group_active;
  logic [PIN_COUNT-1:0] polarity_reg;
  logic [PIN_COUNT-1:0] pin_edge;
  logic irq_reg;

  // known register offsets, shared by read and write decode
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == OFF_FLAGS0 || a == OFF_FLAGS1 || a == OFF_FLAGS2) begin
      hit = 1'b1;
    end
    if (a == OFF_MASK0 || a == OFF_MASK1 || a == OFF_MASK2) begin
      hit = 1'b1;
    end
    if (a == OFF_POLARITY || a == OFF_ACTIVE) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : addr_known

  // byte-lane merge for the software-written mask registers
  function automatic logic [FLAG_W-1:0] merge_strb(
    input logic [FLAG_W-1:0] old_val,
    input logic [FLAG_W-1:0] new_val,
    input logic [1:0] strb
  );
    logic [FLAG_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge_strb

  // handshake outputs
  assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_full_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign write_now = aw_full_reg & w_full_reg & ~bvalid_reg;

  // write address holding
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (write_now) begin
      aw_full_reg <= 1'b0;
    end
  end

  // write data holding, low half only
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA[FLAG_W-1:0];
      w_strb_reg <= S_AXI_WSTRB[1:0];
    end else if (write_now) begin
      w_full_reg <= 1'b0;
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (write_now) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // read data capture, upper half reads zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= addr_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        OFF_FLAGS0: rdata_reg <= {16'h0000, flags[0]};
        OFF_FLAGS1: rdata_reg <= {16'h0000, flags[1]};
        OFF_FLAGS2: rdata_reg <= {16'h0000, flags[2]};
        OFF_MASK0: rdata_reg <= {16'h0000, mask_reg[0]};
        OFF_MASK1: rdata_reg <= {16'h0000, mask_reg[1]};
        OFF_MASK2: rdata_reg <= {16'h0000, mask_reg[2]};
        OFF_POLARITY: rdata_reg <= {29'h0000000, polarity_reg};
        OFF_ACTIVE: rdata_reg <= {29'h0000000, group_active};
        default: rdata_reg <= 32'h00000000;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // edge select for the external pins
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      polarity_reg <= POLARITY_RESET;
    end else if (write_now && aw_addr_reg == OFF_POLARITY && w_strb_reg[0]) begin
      polarity_reg <= w_data_reg[PIN_COUNT-1:0];
    end
  end

  // external pins synchronised before edge detection
  pin_event_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin_async({EXT_PIN2, EXT_PIN1, EXT_PIN0}),
    .falling_sel(polarity_reg),
    .edge_pulse(pin_edge)
  );

  // source requests placed at their flag positions
  always_comb begin
    set_vec = '0;
    set_vec[0][EXT_PIN0_BIT] = pin_edge[0];
    set_vec[0][CAPTURE_CH1_BIT] = CAPTURE_CH1_REQ;
    set_vec[0][COMPARE_CH1_BIT] = COMPARE_CH1_REQ;
    set_vec[0][GROUP0_AUX_MSB:GROUP0_AUX_LSB] = GROUP0_AUX_REQ;
    set_vec[1][SERIAL2_TX_BIT] = SERIAL2_TX_REQ;
    set_vec[1][SERIAL2_RX_BIT] = SERIAL2_RX_REQ;
    set_vec[1][EXT_PIN2_BIT] = pin_edge[2];
    set_vec[1][EXT_PIN1_BIT] = pin_edge[1];
    set_vec[1][TIMER_FIVE_BIT] = TIMER_FIVE_REQ;
    set_vec[1][TIMER_FOUR_BIT] = TIMER_FOUR_REQ;
    set_vec[1][COMPARE_CH4_BIT] = COMPARE_CH4_REQ;
    set_vec[1][COMPARE_CH3_BIT] = COMPARE_CH3_REQ;
    set_vec[1][DMA_CH2_BIT] = DMA_CH2_DONE_REQ;
    set_vec[1][CAPTURE_CH8_BIT] = CAPTURE_CH8_REQ;
    set_vec[1][CAPTURE_CH7_BIT] = CAPTURE_CH7_REQ;
    set_vec[1][CONVERTER2_BIT] = CONVERTER2_DONE_REQ;
    set_vec[1][PIN_CHANGE_BIT] = PIN_CHANGE_REQ;
    set_vec[1][I2C1_MASTER_BIT] = I2C1_MASTER_REQ;
    set_vec[1][I2C1_SLAVE_BIT] = I2C1_SLAVE_REQ;
    set_vec[2][TIMER_SIX_BIT] = TIMER_SIX_REQ;
    set_vec[2][DMA_CH4_BIT] = DMA_CH4_DONE_REQ;
    set_vec[2][COMPARE_CH8_BIT:COMPARE_CH5_BIT] = COMPARE_CH8_5_REQ;
    set_vec[2][CAPTURE_CH6_BIT:CAPTURE_CH3_BIT] = CAPTURE_CH6_3_REQ;
    set_vec[2][DMA_CH3_BIT] = DMA_CH3_DONE_REQ;
    set_vec[2][CAN1_EVENT_BIT] = CAN1_EVENT_REQ;
    set_vec[2][CAN1_RX_BIT] = CAN1_RX_READY_REQ;
    set_vec[2][SPI2_EVENT_BIT] = SPI2_EVENT_REQ;
    set_vec[2][SPI2_ERROR_BIT] = SPI2_ERROR_REQ;
  end

  // one flag bank and one mask per group
  for (genvar g = 0; g < GROUPS; g++) begin : g_group
    logic flag_wr;
    assign flag_wr = write_now && aw_addr_reg == FLAG_OFFSETS[g];

    flag_bank #(
      .WIDTH(FLAG_W),
      .IMPL_MASK(IMPL_MASKS[g]),
      .RESET_VAL(FLAG_RESET)
    ) u_flags (
      .clk(CLK),
      .reset_n(RESET_N),
      .set_vec(set_vec[g]),
      .wr_en(flag_wr),
      .wr_data(w_data_reg),
      .wr_strb(w_strb_reg),
      .flags(flags[g])
    );

    // mask of the same layout as its flags
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        mask_reg[g] <= MASK_RESET;
      end else if (write_now && aw_addr_reg == MASK_OFFSETS[g]) begin
        mask_reg[g] <= merge_strb(mask_reg[g], w_data_reg, w_strb_reg) & IMPL_MASKS[g];
      end
    end

    assign group_active[g] = |(flags[g] & mask_reg[g]);
  end

  // registered combined interrupt
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |group_active;
    end
  end

  // outputs to the core
  assign IRQ = irq_reg;
  assign IRQ_FLAGS_GROUP0 = flags[0];
  assign IRQ_FLAGS_GROUP1 = flags[1];
  assign IRQ_FLAGS_GROUP2 = flags[2];
endmodule : interrupt_flag_status_bank

// ### verilog/irq_flags_pkg.sv
// package: constants for the interrupt flag status bank
package irq_flags_pkg;
  // bus and register geometry
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 16;
  localparam int GROUPS = 3;
  localparam int PIN_COUNT = 3;
  // register byte offsets
  localparam logic [7:0] OFF_FLAGS0 = 8'h00;
  localparam logic [7:0] OFF_FLAGS1 = 8'h04;
  localparam logic [7:0] OFF_FLAGS2 = 8'h08;
  localparam logic [7:0] OFF_MASK0 = 8'h0c;
  localparam logic [7:0] OFF_MASK1 = 8'h10;
  localparam logic [7:0] OFF_MASK2 = 8'h14;
  localparam logic [7:0] OFF_POLARITY = 8'h18;
  localparam logic [7:0] OFF_ACTIVE = 8'h1c;
  localparam logic [GROUPS-1:0][7:0] FLAG_OFFSETS = {OFF_FLAGS2, OFF_FLAGS1, OFF_FLAGS0};
  localparam logic [GROUPS-1:0][7:0] MASK_OFFSETS = {OFF_MASK2, OFF_MASK1, OFF_MASK0};
  // implemented bits and reset values
  localparam logic [FLAG_W-1:0] IMPL0 = 16'h7fff;
  localparam logic [FLAG_W-1:0] IMPL1 = 16'hfffb;
  localparam logic [FLAG_W-1:0] IMPL2 = 16'hdfff;
  localparam logic [GROUPS-1:0][FLAG_W-1:0] IMPL_MASKS = {IMPL2, IMPL1, IMPL0};
  localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [PIN_COUNT-1:0] POLARITY_RESET = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // group 0 positions
  localparam int EXT_PIN0_BIT = 0;
  localparam int CAPTURE_CH1_BIT = 1;
  localparam int COMPARE_CH1_BIT = 2;
  localparam int GROUP0_AUX_LSB = 3;
  localparam int GROUP0_AUX_MSB = 14;
  // group 1 positions
  localparam int SERIAL2_TX_BIT = 15;
  localparam int SERIAL2_RX_BIT = 14;
  localparam int EXT_PIN2_BIT = 13;
  localparam int TIMER_FIVE_BIT = 12;
  localparam int TIMER_FOUR_BIT = 11;
  localparam int COMPARE_CH4_BIT = 10;
  localparam int COMPARE_CH3_BIT = 9;
  localparam int DMA_CH2_BIT = 8;
  localparam int CAPTURE_CH8_BIT = 7;
  localparam int CAPTURE_CH7_BIT = 6;
  localparam int CONVERTER2_BIT = 5;
  localparam int EXT_PIN1_BIT = 4;
  localparam int PIN_CHANGE_BIT = 3;
  localparam int I2C1_MASTER_BIT = 1;
  localparam int I2C1_SLAVE_BIT = 0;
  // group 2 positions
  localparam int TIMER_SIX_BIT = 15;
  localparam int DMA_CH4_BIT = 14;
  localparam int COMPARE_CH8_BIT = 12;
  localparam int COMPARE_CH5_BIT = 9;
  localparam int CAPTURE_CH6_BIT = 8;
  localparam int CAPTURE_CH3_BIT = 5;
  localparam int DMA_CH3_BIT = 4;
  localparam int CAN1_EVENT_BIT = 3;
  localparam int CAN1_RX_BIT = 2;
  localparam int SPI2_EVENT_BIT = 1;
  localparam int SPI2_ERROR_BIT = 0;
endpackage : irq_flags_pkg

// ### verilog/pin_event_sync.sv
// pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module pin_event_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and edge select, 1 = falling
  input wire logic [WIDTH-1:0] pin_async,
  input wire logic [WIDTH-1:0] falling_sel,
  // one-cycle edge pulses
  output logic [WIDTH-1:0] edge_pulse
);
  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] prev_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_event_sync needs at least one pin");
  end

  // two-flop synchroniser plus history flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // active edge: level now at active side, before at idle side
  assign edge_pulse = (sync2_reg ^ falling_sel) & ~(prev_reg ^ falling_sel);
endmodule : pin_event_sync

// ### verilog/flag_bank.sv
// one sticky flag register with set-wins write port
`timescale 1ns/1ps
module flag_bank #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // source requests, high sets
  input wire logic [WIDTH-1:0] set_vec,
  // software write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH/8-1:0] wr_strb,
  // stored flags
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  if (WIDTH % 8 != 0 || WIDTH < 8) begin : g_bad_width
    $error("flag_bank width must be whole bytes");
  end

  // write per byte lane, then source requests on top
  always_comb begin
    flags_next = flags_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (wr_en && wr_strb[i/8]) begin
        flags_next[i] = wr_data[i];
      end
    end
    flags_next = (flags_next | set_vec) & IMPL_MASK;
  end

  // flags held until software clears them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= RESET_VAL & IMPL_MASK;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
endmodule : flag_bank

// ### dv/irq_src_model.sv
// peripheral source model: one-cycle request pulses and pin edges
`timescale 1ns/1ps
module irq_src_model (
  // clock
  input wire logic clk,
  // commanded source
  input wire logic fire,
  input wire logic [1:0] grp,
  input wire logic [3:0] bitn,
  // request pulses by flag position
  output logic [15:0] req0,
  output logic [15:0] req1,
  output logic [15:0] req2,
  // external pins
  output logic pin0,
  output logic pin1,
  output logic pin2
);
  logic [2:0] pin_cnt;
  logic [2:0] pin_sel;
  // idle sources at time zero
  initial begin
    req0 = '0;
    req1 = '0;
    req2 = '0;
    pin_cnt = '0;
    pin_sel = '0;
  end
  // pulse the chosen source, ignoring any enable
  always @(posedge clk) begin
    req0 <= '0;
    req1 <= '0;
    req2 <= '0;
    if (pin_cnt != 3'h0) pin_cnt <= pin_cnt - 3'h1;
    if (fire) begin
      if (grp == 2'h0) req0[bitn] <= 1'b1;
      if (grp == 2'h1) req1[bitn] <= 1'b1;
      if (grp == 2'h2) req2[bitn] <= 1'b1;
      pin_cnt <= 3'h4;
      pin_sel <= {grp == 2'h1 && bitn == 4'hd, grp == 2'h1 && bitn == 4'h4, grp == 2'h0 && bitn == 4'h0};
    end
  end
  // pins rise for four cycles, then fall
  assign pin0 = pin_sel[0] && pin_cnt != 3'h0;
  assign pin1 = pin_sel[1] && pin_cnt != 3'h0;
  assign pin2 = pin_sel[2] && pin_cnt != 3'h0;
endmodule : irq_src_model

// ### dv/interrupt_flag_status_bank_asserts.sv
// checker for the flag bank ports
`timescale 1ns/1ps
module irq_bank_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // bus handshakes
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_BVALID,
  // sources
  input wire logic SERIAL2_TX_REQ,
  input wire logic TIMER_SIX_REQ,
  input wire logic CAN1_EVENT_REQ,
  input wire logic CAN1_RX_READY_REQ,
  input wire logic [3:0] COMPARE_CH8_5_REQ,
  input wire logic [3:0] CAPTURE_CH6_3_REQ,
  // flags and interrupt
  input wire logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP0,
  input wire logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP1,
  input wire logic [irq_flags_pkg::FLAG_W-1:0] IRQ_FLAGS_GROUP2,
  input wire logic IRQ
);
  import irq_flags_pkg::*;
  logic any_flag;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // any flag at all
  assign any_flag = |(IRQ_FLAGS_GROUP0 | IRQ_FLAGS_GROUP1 | IRQ_FLAGS_GROUP2);
  chk_serial2_tx:
    assert property (SERIAL2_TX_REQ |=> IRQ_FLAGS_GROUP1[15]) else $error("serial tx flag");
  chk_timer_six:
    assert property (TIMER_SIX_REQ |=> IRQ_FLAGS_GROUP2[15]) else $error("timer six flag");
  chk_compare_vec:
    assert property (COMPARE_CH8_5_REQ != 4'h0 |=>
      (IRQ_FLAGS_GROUP2[12:9] & $past(COMPARE_CH8_5_REQ)) == $past(COMPARE_CH8_5_REQ))
    else $error("compare flags");
  chk_capture_vec:
    assert property (CAPTURE_CH6_3_REQ != 4'h0 |=>
      (IRQ_FLAGS_GROUP2[8:5] & $past(CAPTURE_CH6_3_REQ)) == $past(CAPTURE_CH6_3_REQ))
    else $error("capture flags");
  chk_can_rx:
    assert property (CAN1_RX_READY_REQ |=> IRQ_FLAGS_GROUP2[2]) else $error("can rx flag");
  chk_unimpl_zero:
    assert property (!IRQ_FLAGS_GROUP0[15] && !IRQ_FLAGS_GROUP1[2] && !IRQ_FLAGS_GROUP2[13])
    else $error("unimplemented bit set");
  chk_flag_sticky:
    assert property ($fell(IRQ_FLAGS_GROUP2[3]) |-> $rose(S_AXI_BVALID)) else $error("flag lost");
  chk_can_cause:
    assert property ($rose(IRQ_FLAGS_GROUP2[3]) |-> $past(CAN1_EVENT_REQ) || $rose(S_AXI_BVALID))
    else $error("can flag without cause");
  chk_irq_cause:
    assert property ($rose(IRQ) |-> $past(any_flag)) else $error("irq without flag");
  chk_read_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
endmodule : irq_bank_checker

bind interrupt_flag_status_bank irq_bank_checker chk_inst (
  .CLK(CLK), .RESET_N(RESET_N), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID), .SERIAL2_TX_REQ(SERIAL2_TX_REQ),
  .TIMER_SIX_REQ(TIMER_SIX_REQ), .CAN1_EVENT_REQ(CAN1_EVENT_REQ),
  .CAN1_RX_READY_REQ(CAN1_RX_READY_REQ), .COMPARE_CH8_5_REQ(COMPARE_CH8_5_REQ),
  .CAPTURE_CH6_3_REQ(CAPTURE_CH6_3_REQ), .IRQ_FLAGS_GROUP0(IRQ_FLAGS_GROUP0),
  .IRQ_FLAGS_GROUP1(IRQ_FLAGS_GROUP1), .IRQ_FLAGS_GROUP2(IRQ_FLAGS_GROUP2), .IRQ(IRQ)
);

// ### dv/tb_top.sv
// testbench for the interrupt flag status bank
`timescale 1ns/1ps
module tb_top;
  import irq_flags_pkg::*;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, fire;
  logic awready, wready, bvalid, arready, rvalid, irq, p0, p1, p2;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb, bitn;
  logic [1:0] bresp, rresp, grp, resp;
  logic [15:0] f0, f1, f2, r0, r1, r2;
  int num_errors, checks_done;
  interrupt_flag_status_bank dut (
    .CLK(clk), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EXT_PIN0(p0), .EXT_PIN1(p1), .EXT_PIN2(p2),
    .CAPTURE_CH1_REQ(r0[1]), .COMPARE_CH1_REQ(r0[2]), .GROUP0_AUX_REQ(r0[14:3]),
    .SERIAL2_TX_REQ(r1[15]), .SERIAL2_RX_REQ(r1[14]), .TIMER_FIVE_REQ(r1[12]),
    .TIMER_FOUR_REQ(r1[11]), .COMPARE_CH4_REQ(r1[10]), .COMPARE_CH3_REQ(r1[9]),
    .DMA_CH2_DONE_REQ(r1[8]), .CAPTURE_CH8_REQ(r1[7]), .CAPTURE_CH7_REQ(r1[6]),
    .CONVERTER2_DONE_REQ(r1[5]), .PIN_CHANGE_REQ(r1[3]), .I2C1_MASTER_REQ(r1[1]),
    .I2C1_SLAVE_REQ(r1[0]), .TIMER_SIX_REQ(r2[15]), .DMA_CH4_DONE_REQ(r2[14]),
    .COMPARE_CH8_5_REQ(r2[12:9]), .CAPTURE_CH6_3_REQ(r2[8:5]), .DMA_CH3_DONE_REQ(r2[4]),
    .CAN1_EVENT_REQ(r2[3]), .CAN1_RX_READY_REQ(r2[2]), .SPI2_EVENT_REQ(r2[1]),
    .SPI2_ERROR_REQ(r2[0]), .IRQ_FLAGS_GROUP0(f0), .IRQ_FLAGS_GROUP1(f1),
    .IRQ_FLAGS_GROUP2(f2), .IRQ(irq)
  );
  irq_src_model src (
    .clk(clk), .fire(fire), .grp(grp), .bitn(bitn), .req0(r0), .req1(r1), .req2(r2),
    .pin0(p0), .pin1(p1), .pin2(p2)
  );
  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // value comparison
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // bus write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [15:0] d);
    logic da, dw, ta, tw, s;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = !da && awready;
      tw = !dw && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do begin
      @(negedge clk);
      s = bvalid;
      resp = bresp;
      @(posedge clk);
    end while (!s);
    bready <= 1'b0;
  endtask : axw
  // bus read
  task automatic axr(input logic [7:0] a);
    logic s;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      s = arready;
      @(posedge clk);
    end while (!s);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      s = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk);
    end while (!s);
    rready <= 1'b0;
  endtask : axr
  // one source request, then settle
  task automatic pulse(input int g, input int b, input int w);
    @(posedge clk);
    fire <= 1'b1;
    grp <= g[1:0];
    bitn <= b[3:0];
    @(posedge clk);
    fire <= 1'b0;
    repeat (w) @(posedge clk);
  endtask : pulse
  // verdict and end of run
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, wdata, wstrb, grp, bitn} = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, then writable and unimplemented bits
    for (int g = 0; g < 3; g++) begin
      axr(FLAG_OFFSETS[g]);
      cmp(got, 32'h0);
      cmp(resp, RESP_OKAY);
      axr(MASK_OFFSETS[g]);
      cmp(got, 32'h0);
      axw(FLAG_OFFSETS[g], 16'hffff);
      cmp(resp, RESP_OKAY);
      axr(FLAG_OFFSETS[g]);
      cmp(got, {16'h0000, IMPL_MASKS[g]});
      axw(FLAG_OFFSETS[g], 16'h0000);
      axr(FLAG_OFFSETS[g]);
      cmp(got, 32'h0);
    end
    // every source alone, sticky until written zero
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 16; b++) begin
        if (IMPL_MASKS[g][b]) begin
          pulse(g, b, 8);
          axr(FLAG_OFFSETS[g]);
          cmp(got, 32'h1 << b);
          cmp({16'h0000, (g == 0) ? f0 : ((g == 1) ? f1 : f2)}, 32'h1 << b);
          axw(FLAG_OFFSETS[g], 16'h0000);
          axr(FLAG_OFFSETS[g]);
          cmp(got, 32'h0);
        end
      end
    end
    // interrupt raised, masked, unmasked, cleared
    axw(OFF_MASK1, 16'h0800);
    pulse(1, TIMER_FOUR_BIT, 8);
    cmp({31'h0, irq}, 32'h1);
    axr(OFF_ACTIVE);
    cmp(got, 32'h2);
    axw(OFF_MASK1, 16'h0000);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    axw(OFF_MASK1, 16'h0800);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    axw(OFF_FLAGS1, 16'h0000);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    // unmapped address
    axr(8'h40);
    cmp(resp, RESP_SLVERR);
    cmp(got, 32'h0);
    axw(8'h40, 16'hffff);
    cmp(resp, RESP_SLVERR);
    // all three pins on their falling edges
    axw(OFF_POLARITY, 16'h0007);
    axr(OFF_POLARITY);
    cmp(got, 32'h7);
    pulse(0, EXT_PIN0_BIT, 12);
    axr(OFF_FLAGS0);
    cmp(got, 32'h1);
    pulse(1, EXT_PIN1_BIT, 12);
    pulse(1, EXT_PIN2_BIT, 12);
    axr(OFF_FLAGS1);
    cmp(got, 32'h2010);
    // group 2 fully unmasked, then a reset in mid-run clears it all
    axw(OFF_MASK2, 16'hffff);
    axr(OFF_MASK2);
    cmp(got, {16'h0000, IMPL2});
    axw(OFF_FLAGS2, 16'hffff);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    cmp({16'h0000, f2}, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    axr(OFF_MASK2);
    cmp(got, 32'h0);
    axr(OFF_FLAGS2);
    cmp(got, 32'h0);
    axr(OFF_POLARITY);
    cmp(got, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
